// [src/hss_pkg.sv]
// Constants for the four-channel high-side switch control block
// Operation
// RL1 - Output driven by register, timer or PWM
// RL2 - Host configures switches in normal mode only; the code also accepts writes in init mode
// RL3 - Stop/sleep keep configuration, ignore changes
// RL4 - Restart or fail-safe forces all outputs off
// RL5 - Supply overvoltage turns outputs off, unless disabled
// RL6 - Overvoltage release re-enables outputs per recovery
// RL7 - Supply undervoltage turns outputs off, unless disabled
// RL8 - Undervoltage release re-enables outputs per recovery
// RL9 - Restore programmed state only with recovery bit one
// RL10 - Without recovery, outputs stay off, configuration cleared
// RL11 - Supply fault sets only its own supply flag
// RL12 - Overcurrent longer than filter time switches off
// RL13 - Overcurrent sets sticky per-output flag until cleared
// RL14 - Overcurrent resets channel configuration to 000
// RL15 - Host re-enables by writing 001 or timer
// RL16 - Open load sets sticky flag, output stays on
// RL17 - Overcurrent filter is sixteen microseconds
// RL18 - Flag clear works only once condition gone
package hss_pkg;

	// ==========================================================
	// Sizes and clock
	localparam int unsigned NCH     = 4;
	localparam int unsigned DW      = 16;
	localparam int unsigned AW      = 4;
	localparam int unsigned CLK_MHZ = 100;

	// ==========================================================
	// Filter times, in microseconds, and their cycle counts
	localparam int unsigned OC_FILTER_US  = 16;
	localparam int unsigned OC_FILTER_CYC = OC_FILTER_US * CLK_MHZ;
	localparam int unsigned OL_FILTER_US  = 64;
	localparam int unsigned OL_FILTER_CYC_DEF = OL_FILTER_US * CLK_MHZ;

	// ==========================================================
	// Register indices
	localparam logic [3:0] REG_CTRL_A      = 4'h0;
	localparam logic [3:0] REG_CTRL_B      = 4'h1;
	localparam logic [3:0] REG_SUPPLY_CTRL = 4'h2;
	localparam logic [3:0] REG_SUPPLY_STAT = 4'h3;
	localparam logic [3:0] REG_OC_STAT     = 4'h4;
	localparam logic [3:0] REG_OL_STAT     = 4'h5;
	localparam logic [3:0] REG_IRQ_STAT    = 4'h6;
	localparam logic [3:0] REG_IRQ_CLR     = 4'h7;
	localparam logic [3:0] REG_IRQ_EN      = 4'h8;
	localparam logic [3:0] REG_OUT_STATE   = 4'h9;

	// ==========================================================
	// Field positions
	localparam int unsigned CFG_W          = 3;
	localparam int unsigned SUP_OV_DIS_POS = 0;
	localparam int unsigned SUP_UV_DIS_POS = 1;
	localparam int unsigned SUP_REC_POS    = 2;
	localparam int unsigned STAT_OV_POS    = 0;
	localparam int unsigned STAT_UV_POS    = 1;
	localparam int unsigned IRQ_W          = 10;
	localparam int unsigned IRQ_OL_POS     = 4;
	localparam int unsigned IRQ_OV_POS     = 8;
	localparam int unsigned IRQ_UV_POS     = 9;

	// ==========================================================
	// Channel configuration codes
	localparam logic [2:0] CFG_OFF  = 3'h0;
	localparam logic [2:0] CFG_ON   = 3'h1;
	localparam logic [2:0] CFG_TMR1 = 3'h2;
	localparam logic [2:0] CFG_TMR2 = 3'h3;
	localparam logic [2:0] CFG_PWM1 = 3'h4;
	localparam logic [2:0] CFG_PWM2 = 3'h5;

	// ==========================================================
	// Device operating mode codes
	localparam logic [2:0] MODE_INIT     = 3'h0;
	localparam logic [2:0] MODE_NORMAL   = 3'h1;
	localparam logic [2:0] MODE_STOP     = 3'h2;
	localparam logic [2:0] MODE_SLEEP    = 3'h3;
	localparam logic [2:0] MODE_RESTART  = 3'h4;
	localparam logic [2:0] MODE_FAILSAFE = 3'h5;

	// ==========================================================
	// Reset values
	localparam logic [15:0] SUPPLY_CTRL_RST = 16'h0004;

endpackage : hss_pkg

// [src/hss_sync.sv]
// Three-stage synchroniser with agreement check for pin inputs
`timescale 1ns/1ps

module hss_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] agree_nxt;

	// A bit moves only when the second and third stages agree
	assign agree_nxt = (s2_r & s3_r) | (level_out & (s2_r | s3_r));

	// ==========================================================
	// Stages; the first stage feeds only the second
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s1_r      <= '0;
			s2_r      <= '0;
			s3_r      <= '0;
			level_out <= '0;
		end else begin
			s1_r      <= pin_in;
			s2_r      <= s1_r;
			s3_r      <= s2_r;
			level_out <= agree_nxt;
		end
	end

endmodule : hss_sync

// [src/hss_filter.sv]
// Persistence filter: one pulse once a condition has held long enough
`timescale 1ns/1ps

module hss_filter #(
	parameter int unsigned CYC = 1600
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic cond,
	output logic      trip
);

	localparam int unsigned CW = $clog2(CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(CYC - 1);
	localparam logic [CW-1:0] DONE = CW'(CYC);

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          trip_nxt;

	// Count saturates at DONE so a steady fault gives a single pulse;
	// any gap in the condition restarts the count
	assign trip_nxt = cond && (cnt_r == LAST);
	assign cnt_nxt  = !cond ? '0 : (cnt_r == DONE) ? cnt_r : cnt_r + 1'b1;

	// ==========================================================
	// Counter and pulse
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			trip  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			trip  <= trip_nxt;
		end
	end

endmodule : hss_filter

// [src/hss_top.sv]
// Control and protection logic for four high-side output switches
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps

module hss_top #(
	parameter int unsigned OL_FILTER_CYC = hss_pkg::OL_FILTER_CYC_DEF
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [15:0] rdata,
	input  wire logic [2:0]  dev_mode,
	input  wire logic        timer1,
	input  wire logic        timer2,
	input  wire logic        pwm1,
	input  wire logic        pwm2,
	input  wire logic        supply_over_in,
	input  wire logic        supply_under_in,
	input  wire logic [3:0]  overcurrent_in,
	input  wire logic [3:0]  open_load_in,
	output logic      [3:0]  high_side_output,
	output logic             irq
);

	localparam int unsigned NCH = hss_pkg::NCH;

	// ==========================================================
	// Synchronised analog comparator levels
	logic       ov_s;
	logic       uv_s;
	logic [3:0] oc_s;
	logic [3:0] ol_s;
	logic       ov_q_r;
	logic       uv_q_r;

	hss_sync #(.W(10)) u_sync (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.pin_in    ({supply_under_in, supply_over_in,
		             open_load_in, overcurrent_in}),
		.level_out ({uv_s, ov_s, ol_s, oc_s})
	);

	// ==========================================================
	// Control registers
	logic [2:0]  cfg_r [NCH];
	logic [15:0] sup_ctrl_r;
	logic [1:0]  sup_stat_r;
	logic [3:0]  oc_flag_r;
	logic [3:0]  ol_flag_r;
	logic [9:0]  irq_stat_r;
	logic [9:0]  irq_en_r;

	// ==========================================================
	// Mode and supply fault decoding
	wire mode_kill = (dev_mode == hss_pkg::MODE_RESTART) ||
	                 (dev_mode == hss_pkg::MODE_FAILSAFE);         // RL4
	// Stop and sleep freeze the configuration taken over from normal
	wire cfg_open  = (dev_mode == hss_pkg::MODE_NORMAL) ||
	                 (dev_mode == hss_pkg::MODE_INIT);             // RL3
	wire ov_dis    = sup_ctrl_r[hss_pkg::SUP_OV_DIS_POS];
	wire uv_dis    = sup_ctrl_r[hss_pkg::SUP_UV_DIS_POS];
	wire rec_en    = sup_ctrl_r[hss_pkg::SUP_REC_POS];
	wire ov_act    = ov_s && !ov_dis;                              // RL5
	wire uv_act    = uv_s && !uv_dis;                              // RL7
	wire sup_fault = ov_act || uv_act;
	// Without recovery a fault wipes the configuration, so the
	// outputs stay off after release until software writes again
	wire sup_wipe  = sup_fault && !rec_en;                         // RL10

	// ==========================================================
	// Register decode
	wire wr_ctrl_a = wr_en && (addr == hss_pkg::REG_CTRL_A);
	wire wr_ctrl_b = wr_en && (addr == hss_pkg::REG_CTRL_B);
	wire wr_sup_c  = wr_en && (addr == hss_pkg::REG_SUPPLY_CTRL);
	wire wr_sup_s  = wr_en && (addr == hss_pkg::REG_SUPPLY_STAT);
	wire wr_oc     = wr_en && (addr == hss_pkg::REG_OC_STAT);
	wire wr_ol     = wr_en && (addr == hss_pkg::REG_OL_STAT);
	wire wr_iclr   = wr_en && (addr == hss_pkg::REG_IRQ_CLR);
	wire wr_ien    = wr_en && (addr == hss_pkg::REG_IRQ_EN);

	// ==========================================================
	// Per-channel source selection, protection and flags
	logic [3:0] src;
	logic [3:0] drive_nxt;
	logic [3:0] oc_trip;
	logic [3:0] ol_trip;
	logic [3:0] oc_flag_nxt;
	logic [3:0] ol_flag_nxt;

	genvar i;
	generate
		for (i = 0; i < NCH; i++) begin : g_ch
			wire [2:0] cfg = cfg_r[i];
			wire       we  = (i < 2) ? wr_ctrl_a : wr_ctrl_b;
			wire [2:0] wv  = wdata[(i % 2) * 3 +: 3];
			// Protection clears beat a host write in the same cycle
			wire       clr = oc_trip[i] || mode_kill || sup_wipe;
			wire [2:0] cfg_nxt = clr ? hss_pkg::CFG_OFF :           // RL14
			                     (we && cfg_open) ? wv : cfg;       // RL3
			wire       oc_clr = wr_oc && wdata[i] && !oc_s[i];      // RL18
			wire       ol_clr = wr_ol && wdata[i] && !ol_s[i];      // RL18

			// Source select: register, timers or PWM generators
			assign src[i] = (cfg == hss_pkg::CFG_ON) ||
			                ((cfg == hss_pkg::CFG_TMR1) && timer1) ||
			                ((cfg == hss_pkg::CFG_TMR2) && timer2) ||
			                ((cfg == hss_pkg::CFG_PWM1) && pwm1) ||
			                ((cfg == hss_pkg::CFG_PWM2) && pwm2);  // RL1
			// Output follows its programmed state once the fault is gone
			assign drive_nxt[i] = src[i] && !sup_fault &&
			                      !mode_kill && !oc_trip[i];  // RL6 RL8 RL9
			assign oc_flag_nxt[i] = oc_trip[i] ||
			                        (oc_flag_r[i] && !oc_clr);      // RL13
			assign ol_flag_nxt[i] = ol_trip[i] ||
			                        (ol_flag_r[i] && !ol_clr);      // RL16

			// Overcurrent filter counts only while the switch is on
			hss_filter #(.CYC(hss_pkg::OC_FILTER_CYC)) u_oc (
				.sys_clk (sys_clk),
				.rst     (rst),
				.cond    (oc_s[i] && high_side_output[i]),
				.trip    (oc_trip[i])
			);                                                  // RL12 RL17

			// Open load is judged only in the on state; no shutdown
			hss_filter #(.CYC(OL_FILTER_CYC)) u_ol (
				.sys_clk (sys_clk),
				.rst     (rst),
				.cond    (ol_s[i] && high_side_output[i]),
				.trip    (ol_trip[i])
			);                                                      // RL16

			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					cfg_r[i] <= hss_pkg::CFG_OFF;
				end else begin
					cfg_r[i] <= cfg_nxt;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Supply flags and interrupt events
	wire       ov_rise = ov_s && !ov_q_r;
	wire       uv_rise = uv_s && !uv_q_r;
	// Supply faults touch only their own flags, never the channel flags
	wire [1:0] sup_set = {uv_rise, ov_rise};                       // RL11
	wire [1:0] sup_clr = wr_sup_s ? wdata[1:0] : 2'h0;
	wire [1:0] sup_stat_nxt = sup_set | (sup_stat_r & ~sup_clr);
	wire [9:0] irq_ev  = {uv_rise, ov_rise, ol_trip, oc_trip};
	wire [9:0] irq_clr = wr_iclr ? wdata[9:0] : 10'h000;
	// Set beats clear so an event in the clearing cycle survives
	wire [9:0] irq_stat_nxt = irq_ev | (irq_stat_r & ~irq_clr);

	// ==========================================================
	// Read multiplexer; unmapped and write-only indices read zero
	logic [15:0] rd_mux;
	assign rd_mux =
		(addr == hss_pkg::REG_CTRL_A) ?
			{10'h000, cfg_r[1], cfg_r[0]} :
		(addr == hss_pkg::REG_CTRL_B) ?
			{10'h000, cfg_r[3], cfg_r[2]} :
		(addr == hss_pkg::REG_SUPPLY_CTRL) ? {13'h0000, sup_ctrl_r[2:0]} :
		(addr == hss_pkg::REG_SUPPLY_STAT) ? {14'h0000, sup_stat_r} :
		(addr == hss_pkg::REG_OC_STAT)     ? {12'h000, oc_flag_r} :
		(addr == hss_pkg::REG_OL_STAT)     ? {12'h000, ol_flag_r} :
		(addr == hss_pkg::REG_IRQ_STAT)    ? {6'h00, irq_stat_r} :
		(addr == hss_pkg::REG_IRQ_EN)      ? {6'h00, irq_en_r} :
		(addr == hss_pkg::REG_OUT_STATE)   ? {12'h000, high_side_output} :
		16'h0000;

	// ==========================================================
	// Shared registers; supply control may be set in any mode
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sup_ctrl_r <= hss_pkg::SUPPLY_CTRL_RST;
			irq_en_r   <= 10'h000;
		end else begin
			if (wr_sup_c) begin
				sup_ctrl_r <= {13'h0000, wdata[2:0]};
			end
			if (wr_ien) begin
				irq_en_r <= wdata[9:0];
			end
		end
	end

	// Status flags and delayed supply levels for edge detection
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sup_stat_r <= 2'h0;
			oc_flag_r  <= 4'h0;
			ol_flag_r  <= 4'h0;
			irq_stat_r <= 10'h000;
			ov_q_r     <= 1'b0;
			uv_q_r     <= 1'b0;
		end else begin
			sup_stat_r <= sup_stat_nxt;
			oc_flag_r  <= oc_flag_nxt;
			ol_flag_r  <= ol_flag_nxt;
			irq_stat_r <= irq_stat_nxt;
			ov_q_r     <= ov_s;
			uv_q_r     <= uv_s;
		end
	end

	// Outputs, all registered; read data stands one cycle only
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			high_side_output <= 4'h0;
			irq              <= 1'b0;
			rdata            <= 16'h0000;
		end else begin
			high_side_output <= drive_nxt;
			irq              <= |(irq_stat_r & irq_en_r);
			rdata            <= rd_en ? rd_mux : 16'h0000;
		end
	end

endmodule : hss_top

// [sim/hss_assertions.sv]
// Checker for the high-side switch control block
`timescale 1ns/1ps

module hss_chk #(
	parameter int unsigned OL_FILTER_CYC = 20
) (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic [3:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr_en,
	input wire logic [2:0]  dev_mode,
	input wire logic        timer1,
	input wire logic        timer2,
	input wire logic        pwm1,
	input wire logic        pwm2,
	input wire logic        supply_over_in,
	input wire logic        supply_under_in,
	input wire logic [3:0]  overcurrent_in,
	input wire logic [3:0]  high_side_output,
	input wire logic        irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic        ov_dis_r;
	logic        uv_dis_r;
	logic        rec_r;
	logic [10:0] oc_cnt_r;
	wire         sup_wr = wr_en && addr == hss_pkg::REG_SUPPLY_CTRL;
	wire         low_md = dev_mode == hss_pkg::MODE_STOP
		|| dev_mode == hss_pkg::MODE_SLEEP;
	wire         quiet = low_md && !wr_en && overcurrent_in == 4'h0;

	// ==========================================================
	// Shadow supply bits: the checker only sees pins, not registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			{rec_r, uv_dis_r, ov_dis_r} <= hss_pkg::SUPPLY_CTRL_RST[2:0];
			oc_cnt_r <= 11'h0;
		end else begin
			if (sup_wr)
				{rec_r, uv_dis_r, ov_dis_r} <= wdata[2:0];
			oc_cnt_r <= (high_side_output[0] && overcurrent_in[0])
				? oc_cnt_r + 11'h1 : 11'h0;
		end
	end

	property p_restart_off;
		(dev_mode == hss_pkg::MODE_RESTART)[*2] |-> high_side_output == 4'h0;
	endproperty
	a_restart_off: assert property (p_restart_off)
		else $error("output on in restart");
	property p_failsafe_off;
		$past(dev_mode) == hss_pkg::MODE_FAILSAFE
			&& dev_mode == hss_pkg::MODE_FAILSAFE |-> high_side_output == 4'h0;
	endproperty
	a_failsafe_off: assert property (p_failsafe_off)
		else $error("output on in fail-safe");
	// Quiet low-power window: outputs must not move
	property p_stop_hold;
		(quiet && $stable({timer1, timer2, pwm1, pwm2, supply_over_in,
			supply_under_in}))[*8] |=> $stable(high_side_output);
	endproperty
	a_stop_hold: assert property (p_stop_hold)
		else $error("output moved in low-power mode");
	property p_ov_off;
		(supply_over_in && !ov_dis_r)[*8] |-> high_side_output == 4'h0;
	endproperty
	a_ov_off: assert property (p_ov_off)
		else $error("output on in overvoltage");
	property p_uv_off;
		(supply_under_in && !uv_dis_r)[*8] |-> high_side_output == 4'h0;
	endproperty
	a_uv_off: assert property (p_uv_off)
		else $error("output on in undervoltage");
	property p_ov_norec;
		(supply_over_in && !ov_dis_r && !rec_r)[*6] ##1
			(!supply_over_in && !wr_en)[*8] |-> high_side_output == 4'h0;
	endproperty
	a_ov_norec: assert property (p_ov_norec)
		else $error("output back after overvoltage");
	property p_uv_norec;
		(supply_under_in && !uv_dis_r && !rec_r)[*6] ##1
			(!supply_under_in && !wr_en)[*8] |-> high_side_output == 4'h0;
	endproperty
	a_uv_norec: assert property (p_uv_norec)
		else $error("output back after undervoltage");
	// Sync latency plus filter stays below this bound
	property p_oc_trip;
		high_side_output[0] && overcurrent_in[0] |-> oc_cnt_r < 11'h654;
	endproperty
	a_oc_trip: assert property (p_oc_trip)
		else $error("overcurrent not tripped");

	c_oc: cover property ($fell(high_side_output[0]) && overcurrent_in[0]);
	c_irq: cover property ($rose(irq));
	c_quiet: cover property (quiet[*8]);
endmodule : hss_chk

bind hss_top hss_chk #(.OL_FILTER_CYC(OL_FILTER_CYC)) u_chk (.sys_clk,
	.rst, .addr, .wdata, .wr_en, .dev_mode, .timer1, .timer2, .pwm1,
	.pwm2, .supply_over_in, .supply_under_in, .overcurrent_in,
	.high_side_output, .irq);

// [sim/hss_host.sv]
// Host model: register accesses plus read-result scoreboard
`timescale 1ns/1ps

module hss_host (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	output logic      [3:0]  addr,
	output logic      [15:0] wdata,
	output logic             wr_en,
	output logic             rd_en,
	input  wire logic [15:0] rdata
);
	int          err_count = 0;
	int          samples_checked = 0;
	logic [15:0] exp_q[$];
	logic        pend_r = 1'b0;

	initial begin
		addr = 4'h0;
		wdata = 16'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
	end

	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s exp %h got %h", nm, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask : wr

	// Expectation is queued before the strobe goes out
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		exp_q.push_back(exp);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
	endtask : rd

	// ==========================================================
	// Read data stand only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (pend_r)
			check("rdata", rdata, exp_q.pop_front());
		pend_r <= rd_en && !rst;
	end
endmodule : hss_host

// [sim/tb_high_side_switch_control.sv]
// Testbench for the high-side switch control block
`timescale 1ns/1ps

module tb_high_side_switch_control;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  addr;
	logic [15:0] wdata;
	logic        wr_en;
	logic        rd_en;
	logic [15:0] rdata;
	logic [2:0]  dev_mode = hss_pkg::MODE_NORMAL;
	logic        timer1 = 1'b1;
	logic        timer2 = 1'b0;
	logic        pwm1 = 1'b1;
	logic        pwm2 = 1'b0;
	logic        supply_over_in = 1'b0;
	logic        supply_under_in = 1'b0;
	logic [3:0]  overcurrent_in = 4'h0;
	logic [3:0]  open_load_in = 4'h0;
	logic [3:0]  high_side_output;
	logic        irq;
	int          seed = 32'h52fa;

	always #5 sys_clk = ~sys_clk;

	// Short open-load filter keeps the run brief
	hss_top #(.OL_FILTER_CYC(20)) u_dut (.sys_clk, .rst, .addr, .wdata,
		.wr_en, .rd_en, .rdata, .dev_mode, .timer1, .timer2, .pwm1, .pwm2,
		.supply_over_in, .supply_under_in, .overcurrent_in, .open_load_in,
		.high_side_output, .irq);
	hss_host u_host (.sys_clk, .rst, .addr, .wdata, .wr_en, .rd_en,
		.rdata);

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc

	// ch0 on, ch1 timer1, ch2 pwm1, ch3 timer2
	task automatic cfg_all;
		u_host.wr(4'h0, 16'h0011);
		u_host.wr(4'h1, 16'h001C);
	endtask : cfg_all

	task automatic tally_and_finish;
		if (u_host.err_count == 0 && u_host.samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	// ==========================================================
	// Main sequence
	initial begin
		cyc(6);
		rst <= 1'b0;
		u_host.rd(4'h2, 16'h0004);
		u_host.wr(4'hF, 16'hFFFF);
		u_host.rd(4'hF, 16'h0000);
		cfg_all();
		u_host.rd(4'h9, 16'h0007);
		pwm1 <= 1'b0;
		cyc(3);
		u_host.rd(4'h9, 16'h0003);
		dev_mode <= hss_pkg::MODE_STOP;
		u_host.wr(4'h0, 16'($random(seed)));
		cyc(10);
		u_host.rd(4'h0, 16'h0011);
		u_host.rd(4'h9, 16'h0003);
		dev_mode <= hss_pkg::MODE_SLEEP;
		u_host.wr(4'h1, 16'($random(seed)));
		u_host.rd(4'h1, 16'h001C);
		for (int m = 4; m < 6; m++) begin
			dev_mode <= 3'(m);
			cyc(3);
			u_host.rd(4'h9, 16'h0000);
			u_host.rd(4'h0, 16'h0000);
		end
		dev_mode <= hss_pkg::MODE_NORMAL;
		cfg_all();
		supply_over_in <= 1'b1;
		cyc(10);
		u_host.rd(4'h9, 16'h0000);
		u_host.rd(4'h4, 16'h0000);
		supply_over_in <= 1'b0;
		cyc(10);
		u_host.rd(4'h9, 16'h0003);
		u_host.wr(4'h3, 16'h0003);
		u_host.wr(4'h2, 16'h0000);
		// Recovery off: both supply faults leave outputs dark
		for (int i = 0; i < 2; i++) begin
			cfg_all();
			{supply_under_in, supply_over_in} <= 2'(1 << i);
			cyc(10);
			u_host.rd(4'h9, 16'h0000);
			u_host.rd(4'h3, 16'(1 << i));
			{supply_under_in, supply_over_in} <= 2'b00;
			cyc(10);
			u_host.rd(4'h9, 16'h0000);
			u_host.rd(4'h0, 16'h0000);
			u_host.wr(4'h3, 16'h0003);
		end
		u_host.wr(4'h2, 16'h0003);
		cfg_all();
		supply_over_in <= 1'b1;
		cyc(10);
		u_host.rd(4'h9, 16'h0003);
		supply_over_in <= 1'b0;
		u_host.wr(4'h2, 16'h0004);
		u_host.wr(4'h3, 16'h0003);
		overcurrent_in <= 4'h1;
		cyc(1500);
		overcurrent_in <= 4'h0;
		cyc(10);
		u_host.rd(4'h9, 16'h0003);
		overcurrent_in <= 4'h1;
		cyc(1620);
		u_host.rd(4'h9, 16'h0002);
		u_host.rd(4'h4, 16'h0001);
		u_host.rd(4'h0, 16'h0010);
		u_host.wr(4'h4, 16'h0001);
		u_host.rd(4'h4, 16'h0001);
		overcurrent_in <= 4'h0;
		cyc(10);
		u_host.wr(4'h4, 16'h0001);
		u_host.rd(4'h4, 16'h0000);
		u_host.wr(4'h0, 16'h0011);
		u_host.rd(4'h9, 16'h0003);
		u_host.wr(4'h8, 16'h0010);
		open_load_in <= 4'h1;
		cyc(40);
		u_host.rd(4'h9, 16'h0003);
		u_host.rd(4'h5, 16'h0001);
		u_host.check("irq", {15'h0, irq}, 16'h0001);
		u_host.wr(4'h8, 16'h0000);
		cyc(3);
		u_host.check("irq", {15'h0, irq}, 16'h0000);
		u_host.wr(4'h8, 16'h0010);
		open_load_in <= 4'h0;
		cyc(10);
		u_host.wr(4'h5, 16'h0001);
		u_host.rd(4'h6, 16'h0311);
		u_host.wr(4'h7, 16'h03FF);
		u_host.rd(4'h6, 16'h0000);
		cyc(3);
		u_host.check("irq", {15'h0, irq}, 16'h0000);
		u_host.rd(4'h5, 16'h0000);
		cyc(4);
		tally_and_finish();
	end

	// Whole run is about 3400 cycles; cut a hang well past that
	initial begin
		#200000;
		u_host.err_count++;
		tally_and_finish();
	end
endmodule : tb_high_side_switch_control
